// [src/cmb_pkg.sv]
// Functional notes
// (RQ1) word 1 holds extended id bits 17..6 in bits 11..0, upper four read zero
// (RQ2) word 2 bits 15..10 hold extended id bits 5..0
// (RQ3) word 2 bit 9 is remote flag, honoured only for extended frames
// (RQ4) software loads zero into reserved bits 8 and 4 of word 2
// (RQ5) word 2 bits 3..0 hold length code, bits 7..5 read zero
// (RQ6) words 3..6 hold payload pairs, even byte low, odd byte high
// (RQ7) word 7 bits 12..8 hold filter match code, rest reads zero
// (RQ8) filter match code written only when storing a received message; software writes to word 7 also set it
// (RQ9) word 0 bit 0 selects extended identifier format
// (RQ10) word 0 bits 12..2 hold standard id, forming 29-bit id with words 1-2
// (RQ11) software sets substitute remote bit for extended frames
// (RQ12) buffers live in ordinary ram written directly by software
// (RQ13) receive fills all fields, transmit reads the same fields
// (RQ14) payload bytes past the length code are don't-care
package cmb_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS = 8;
  // word indices inside one buffer
  localparam logic [2:0] W_STD = 3'h0;
  localparam logic [2:0] W_EXTH = 3'h1;
  localparam logic [2:0] W_EXTL = 3'h2;
  localparam logic [2:0] W_PAY0 = 3'h3;
  localparam logic [2:0] W_FILT = 3'h7;
  // register offsets: buffer words, then control and status
  localparam logic [3:0] OFF_WORD0 = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'h9;
  // field masks per word
  localparam logic [15:0] MASK_W0 = 16'h1fff;
  localparam logic [15:0] MASK_W1 = 16'h0fff;
  localparam logic [15:0] MASK_W2 = 16'hff1f;
  localparam logic [15:0] MASK_PAY = 16'hffff;
  localparam logic [15:0] MASK_W7 = 16'h1f00;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int unsigned EXT_BIT = 0;
  localparam int unsigned RTR_BIT = 9;

  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic remote;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmb_frame_s;
endpackage

// [src/cmb_buffer.sv]
`timescale 1ns/10ps
`default_nettype none
module cmb_buffer #(
  parameter int unsigned FILT_W = 5
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [cmb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cmb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [cmb_pkg::DATA_W-1:0] rdata_o,
  // receive store from the controller
  input wire logic rx_store_i,
  input wire cmb_pkg::cmb_frame_s rx_frame_i,
  input wire logic [FILT_W-1:0] rx_filter_i,
  // transmit view toward the controller
  output cmb_pkg::cmb_frame_s tx_frame_o,
  output logic tx_request_o
);
  // the word 7 field is exactly five bits wide, so no other code width fits
  if (FILT_W != 5) begin : g_filt_w_check
    $error("filter code must be five bits");
  end

  logic [15:0] mem_q [cmb_pkg::WORDS];
  logic [15:0] rdata_q;
  logic [15:0] ctrl_q;
  logic rx_done_q;
  logic [15:0] mask [cmb_pkg::WORDS];
  logic [15:0] rx_word [cmb_pkg::WORDS];
  logic is_tx, tx_ext;
  wire logic in_buf = (addr_i[3] == 1'b0);
  wire logic [2:0] widx = addr_i[2:0];

  // field layout of words: store masks keep unimplemented bits zero
  assign mask[0] = cmb_pkg::MASK_W0;
  assign mask[1] = cmb_pkg::MASK_W1; // RQ1
  assign mask[2] = cmb_pkg::MASK_W2; // RQ5
  assign mask[3] = cmb_pkg::MASK_PAY;
  assign mask[4] = cmb_pkg::MASK_PAY;
  assign mask[5] = cmb_pkg::MASK_PAY;
  assign mask[6] = cmb_pkg::MASK_PAY;
  assign mask[7] = cmb_pkg::MASK_W7; // RQ7

  // received frame packed into buffer words; reserved bits stored zero
  assign rx_word[0] = {3'h0, rx_frame_i.id[28:18], rx_frame_i.ext, rx_frame_i.ext}; // RQ10 RQ9
  assign rx_word[1] = {4'h0, rx_frame_i.id[17:6]}; // RQ1
  assign rx_word[2] = {rx_frame_i.id[5:0], rx_frame_i.remote, 1'b0, 3'h0, 1'b0, rx_frame_i.dlc}; // RQ2 RQ5
  assign rx_word[7] = {3'h0, rx_filter_i, 8'h00}; // RQ7

  // payload words, even byte in low half
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pay
      assign rx_word[3+g] = {rx_frame_i.data[16*g+15 -: 8], rx_frame_i.data[16*g+7 -: 8]}; // RQ6
    end
  endgenerate

  // control bit 0 marks buffer for transmit, bit 1 requests send
  assign is_tx = ctrl_q[0];
  assign tx_request_o = ctrl_q[1] & is_tx;

  // named steps shared by the store and status properties
  sequence s_rx_store;
    rx_store_i && !is_tx;
  endsequence
  // a store attempt that the transmit marking must refuse
  sequence s_tx_refused;
    rx_store_i && is_tx && !wr_i;
  endsequence
  // a clear of the done flag with no store racing it
  sequence s_done_clear;
    wr_i && addr_i == cmb_pkg::OFF_STAT && wdata_i[0] && !(rx_store_i && !is_tx);
  endsequence

  // a send request from a receive buffer would put stale words on the bus
  a_req_tx_only: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ13
    tx_request_o |-> is_tx)
    else $error("send request on receive buffer");

  // buffer words: software writes any time; receive store only on rx buffers
  always_ff @(posedge sys_clk_i) begin
    if (wr_i && in_buf) begin
      mem_q[widx] <= wdata_i & mask[widx]; // RQ12
    end
    if (rx_store_i && !is_tx) begin
      for (int i = 0; i < 7; i++) begin
        mem_q[i] <= rx_word[i]; // RQ13
      end
      mem_q[7] <= rx_word[7]; // RQ8
    end
  end

  // each receive store lands whole, one edge after the strobe
  a_rx_word0: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ10
    s_rx_store |=> mem_q[0][12:0] == {$past(rx_frame_i.id[28:18]), {2{$past(rx_frame_i.ext)}}})
    else $error("word0 not stored");
  a_rx_word1: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ1
    s_rx_store |=> mem_q[1] == {4'h0, $past(rx_frame_i.id[17:6])})
    else $error("word1 not stored");
  a_rx_word2: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ2
    s_rx_store |=> mem_q[2] == {$past(rx_frame_i.id[5:0]), $past(rx_frame_i.remote), 5'h00, $past(rx_frame_i.dlc)})
    else $error("word2 not stored");
  // reserved bits are stored clear whatever the controller hands over
  a_rx_reserved: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ13
    s_rx_store |=> !mem_q[2][8] && !mem_q[2][4])
    else $error("reserved bits stored set");
  // software writes land masked unless a store wins the same edge
  a_sw_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ12
    (wr_i && in_buf && !(rx_store_i && !is_tx)) |=> mem_q[$past(widx)] == ($past(wdata_i) & $past(mask[widx])))
    else $error("software write lost");
  // a transmit buffer keeps every word when the controller tries to store
  a_tx_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ8
    s_tx_refused |=> $stable(tx_frame_o) && $stable(mem_q[7]))
    else $error("store reached transmit buffer");

  // control register and receive-done status; hardware set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= cmb_pkg::CTRL_RESET;
      rx_done_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == cmb_pkg::OFF_CTRL) ctrl_q <= wdata_i & 16'h0003;
      if (wr_i && addr_i == cmb_pkg::OFF_STAT && wdata_i[0]) rx_done_q <= 1'b0;
      if (rx_store_i && !is_tx) rx_done_q <= 1'b1;
    end
  end

  // the store sets done even when software clears in the same cycle
  a_done_set: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ13
    s_rx_store |=> rx_done_q)
    else $error("receive done not set");
  a_done_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_done_clear |=> !rx_done_q)
    else $error("receive done not cleared");
  // only the two control bits exist, the rest stay zero
  a_ctrl_spare: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ctrl_q[15:2] == 14'h0000)
    else $error("spare control bits set");
  // reset clears control, status and the read register in one edge
  a_reset_state: assert property (@(posedge sys_clk_i)
    srst_i |=> ctrl_q == cmb_pkg::CTRL_RESET && !rx_done_q && rdata_o == 16'h0000)
    else $error("reset state wrong");

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) rdata_q <= 16'h0000;
    else if (rd_i) begin
      if (in_buf) rdata_q <= mem_q[widx] & mask[widx];
      else if (addr_i == cmb_pkg::OFF_CTRL) rdata_q <= ctrl_q;
      else if (addr_i == cmb_pkg::OFF_STAT) rdata_q <= {15'h0, rx_done_q};
      else rdata_q <= 16'h0000;
    end
  end
  assign rdata_o = rdata_q;

  // reads answer exactly one edge after the strobe
  a_ctrl_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == cmb_pkg::OFF_CTRL) |=> rdata_o == $past(ctrl_q))
    else $error("control read wrong");
  a_stat_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == cmb_pkg::OFF_STAT) |=> rdata_o == {15'h0, $past(rx_done_q)})
    else $error("status read wrong");
  a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && !in_buf && addr_i != cmb_pkg::OFF_CTRL && addr_i != cmb_pkg::OFF_STAT) |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_word0_upper_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ10
    (rd_i && in_buf && widx == 3'h0) |=> rdata_o[15:13] == 3'h0)
    else $error("word0 upper bits set");

  // transmit view built from stored words; remote ignored for standard frames
  assign tx_ext = mem_q[0][cmb_pkg::EXT_BIT]; // RQ9
  always_comb begin
    tx_frame_o.ext = tx_ext;
    tx_frame_o.id = tx_ext ? {mem_q[0][12:2], mem_q[1][11:0], mem_q[2][15:10]} // RQ10
                           : {18'h00000, mem_q[0][12:2]};
    tx_frame_o.remote = tx_ext & mem_q[2][cmb_pkg::RTR_BIT]; // RQ3
    tx_frame_o.dlc = mem_q[2][3:0];
    // bytes past the length code are passed but carry no meaning
    tx_frame_o.data = {mem_q[6], mem_q[5], mem_q[4], mem_q[3]}; // RQ14
  end

  // remote gating both ways: the gate alone would pass a stuck-low flag
  a_remote_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ3
    !tx_ext |-> !tx_frame_o.remote)
    else $error("remote set on standard frame");
  a_remote_pass: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ3
    (tx_ext && mem_q[2][cmb_pkg::RTR_BIT]) |-> tx_frame_o.remote)
    else $error("remote lost on extended frame");
  // standard frames carry their eleven bits low and nothing above
  a_std_id_upper: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ10
    !tx_ext |-> tx_frame_o.id[28:11] == 18'h00000)
    else $error("standard id upper bits set");

  // the filter code moves on receive stores, and on transmit buffers only by software writes
  a_filter_tx_kept: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ8
    (is_tx && !wr_i) |=> $stable(mem_q[7]))
    else $error("filter code changed on tx buffer");
  a_rx_filter_stored: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ7
    (rx_store_i && !is_tx) |=> mem_q[7][12:8] == $past(rx_filter_i))
    else $error("filter code not stored");
  // unimplemented bits always read back as zero
  a_word1_upper_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ1
    (rd_i && addr_i == 4'h1) |=> rdata_o[15:12] == 4'h0)
    else $error("word1 upper bits set");
  a_word2_gap_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ5
    (rd_i && addr_i == 4'h2) |=> rdata_o[7:5] == 3'h0)
    else $error("word2 unused bits set");
  a_word7_low_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ7
    (rd_i && addr_i == 4'h7) |=> rdata_o[7:0] == 8'h00)
    else $error("word7 low bits set");

  // receive words reassemble into the transmit view
  a_ext_id_split: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ2
    (rx_store_i && !is_tx && rx_frame_i.ext && !wr_i) |=> tx_frame_o.id == $past(rx_frame_i.id))
    else $error("extended id not reassembled");
  a_payload_order: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ6
    (rx_store_i && !is_tx && !wr_i) |=> tx_frame_o.data == $past(rx_frame_i.data))
    else $error("payload order wrong");
  // the length code reaches the transmit view unchanged
  a_dlc_pass: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RQ5
    s_rx_store |=> tx_frame_o.dlc == $past(rx_frame_i.dlc))
    else $error("length code not passed");
endmodule
`default_nettype wire

// [verif/cmb_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cmb_ctrl_model (
  // clock
  input wire logic sys_clk_i,
  // command from the bench
  input wire logic go_i,
  input wire cmb_pkg::cmb_frame_s frame_i,
  input wire logic [4:0] filter_i,
  // store path into the buffer
  output logic store_o,
  output cmb_pkg::cmb_frame_s frame_o,
  output logic [4:0] filter_o
);
  // inverse data outside the store cycle, so stale values never pass
  always_ff @(posedge sys_clk_i) begin
    store_o <= go_i;
    frame_o <= go_i ? frame_i : ~frame_i;
    filter_o <= go_i ? filter_i : ~filter_i;
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, st, treq;
  logic [3:0] a = 4'h0;
  logic [15:0] wd = 16'h0000, rdata;
  logic [15:0] v [8];
  logic [15:0] e [8];
  logic [4:0] fil = 5'h15, m_fil;
  cmb_pkg::cmb_frame_s fr = '0, m_fr, tx;
  cmb_pkg::cmb_frame_s f0 = '{id: 29'h1abcdef1, ext: 1'b1, remote: 1'b1, dlc: 4'h8, data: 64'h0123456789abcdef};
  int miscompares = 0, n_tests = 0;
  // bench clock, 8 ns period
  always #4 clk = ~clk;
  cmb_buffer uut (.sys_clk_i(clk), .srst_i(rst), .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .rx_store_i(st), .rx_frame_i(m_fr), .rx_filter_i(m_fil), .tx_frame_o(tx),
    .tx_request_o(treq));
  cmb_ctrl_model peer (.sys_clk_i(clk), .go_i(go), .frame_i(fr), .filter_i(fil), .store_o(st),
    .frame_o(m_fr), .filter_o(m_fil));
  // four-state compare, counts every check
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe; the gap edge avoids double assignment
  task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands from the cycle after the strobe until the next read
  task automatic rreg(input logic [3:0] ad, input logic [15:0] ex);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, ex);
  endtask
  // controller stores one received frame
  task automatic rx(input logic [4:0] f);
    @(posedge clk);
    fil <= f;
    fr <= f0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence: reset values, masks, transmit view, receive store
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(cmb_pkg::OFF_CTRL, cmb_pkg::CTRL_RESET);
    rreg(cmb_pkg::OFF_STAT, 16'h0000);
    rreg(4'hf, 16'h0000);
    // patterns keep reserved bits of word 2 clear and the substitute remote bit set
    for (int i = 0; i < 8; i++) begin
      v[i] = 16'hfeef ^ (16'h1010 * i[15:0]);
      wreg(i[3:0], v[i]);
    end
    wreg(cmb_pkg::OFF_CTRL, 16'h0003);
    e = '{cmb_pkg::MASK_W0, cmb_pkg::MASK_W1, cmb_pkg::MASK_W2, cmb_pkg::MASK_PAY, cmb_pkg::MASK_PAY,
      cmb_pkg::MASK_PAY, cmb_pkg::MASK_PAY, cmb_pkg::MASK_W7};
    for (int i = 0; i < 8; i++) rreg(i[3:0], v[i] & e[i]);
    chk(tx.id, {v[0][12:2], v[1][11:0], v[2][15:10]});
    chk(tx.remote, v[2][9]);
    chk(tx.dlc, v[2][3:0]);
    chk(tx.data, {v[6], v[5], v[4], v[3]});
    chk(treq, 1'b1);
    wreg(4'h0, v[0] & 16'hfffe);
    #1 chk(tx.id, {18'h0, v[0][12:2]});
    chk(tx.ext, 1'b0);
    chk(tx.remote, 1'b0);
    wreg(cmb_pkg::OFF_CTRL, 16'h0002);
    #1 chk(treq, 1'b0);
    rx(5'h15);
    e = '{{3'h0, f0.id[28:18], 2'b11}, {4'h0, f0.id[17:6]}, {f0.id[5:0], 6'h20, f0.dlc}, f0.data[15:0],
      f0.data[31:16], f0.data[47:32], f0.data[63:48], {3'h0, 5'h15, 8'h00}};
    for (int i = 0; i < 8; i++) rreg(i[3:0], e[i]);
    rreg(cmb_pkg::OFF_STAT, 16'h0001);
    wreg(cmb_pkg::OFF_STAT, 16'h0001);
    rreg(cmb_pkg::OFF_STAT, 16'h0000);
    wreg(cmb_pkg::OFF_CTRL, 16'h0001);
    #1 chk(treq, 1'b0);
    chk(tx.id, f0.id);
    chk(tx.remote, f0.remote);
    chk(tx.data, f0.data);
    // a store attempt on a transmit buffer must leave words and status alone
    rx(5'h0a);
    rreg(4'h7, e[7]);
    rreg(4'h2, e[2]);
    rreg(cmb_pkg::OFF_STAT, 16'h0000);
    // mid-run reset drops the transmit marking
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rreg(cmb_pkg::OFF_CTRL, cmb_pkg::CTRL_RESET);
    print_verdict();
  end
endmodule
`default_nettype wire
